// ===== src/bhp_pkg.sv
// Package of constants and types for the bus address histogram profiler
package bhp_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_BINS = 15;
	localparam int ADDR_W = 20;
	localparam int NARROW_W = 16;
	localparam int TIME_W = 16;
	localparam int COUNT_W = 32;
	localparam int BIN_IDX_W = 4;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESOLUTION_NS = 20000;
	localparam int TICK_CYCLES = RESOLUTION_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 11;
	localparam int STEP_W = 10;
	// Number of 10 us steps in each selectable time unit
	localparam logic [STEP_W-1:0] STEPS_100US = 10'h00A;
	localparam logic [STEP_W-1:0] STEPS_1MS = 10'h064;
	localparam logic [STEP_W-1:0] STEPS_10MS = 10'h3E8;
	localparam logic [STEP_W-1:0] STEPS_PER_TICK = 10'h002;

	// ----------------------------------------
	// Masks and reset values
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] MASK_NARROW = 20'h0FFFF;
	localparam logic [ADDR_W-1:0] MASK_WIDE = 20'hFFFFF;
	localparam logic [TIME_W-1:0] TIME_MAX = 16'hFFFF;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 32'hFFFFFFFF;
	localparam logic [COUNT_W-1:0] COUNT_RST = 32'h00000000;
	localparam logic [BIN_IDX_W-1:0] LAST_BIN = 4'hE;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		UNIT_10US = 2'b00,
		UNIT_100US = 2'b01,
		UNIT_1MS = 2'b10,
		UNIT_10MS = 2'b11
	} bhp_unit_e;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_TIMING = 1'b1
	} bhp_state_e;

	// One bin: enable and inclusive limits (address or time units)
	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] lo;
		logic [ADDR_W-1:0] hi;
	} bhp_bin_s;

	// Bin write from host
	typedef struct packed {
		logic wr;
		logic [BIN_IDX_W-1:0] idx;
		bhp_bin_s bin;
	} bhp_bin_wr_s;

	// Count report to host
	typedef struct packed {
		logic [BIN_IDX_W-1:0] bin;
		logic [COUNT_W-1:0] count;
	} bhp_report_s;
endpackage : bhp_pkg

// ===== src/bhp_profiler.sv
// Histogram profiler: address bins and interval timing bins
// Behaviour
// - Address profiling holds up to fifteen bins, each a start and end address written by the host.
// - While address profiling runs, each executed address inside a bin adds one to that bin's count.
// - Bin counts stream to the host continuously while run is high, without any request per transfer.
// - Interval profiling counts each measured interval into up to fifteen elapsed-time ranges.
// - The interval timer starts when the configured start address is seen on the bus.
// - The timer stops at the configured end address and the interval is then binned.
// - Without the end address the timer keeps running and no measurement completes.
// - The time unit is chosen in decade steps from 10 us up to 10 ms.
// - Interval measurement has a true resolution of 20 us, so results may read up to 20 us short.
// - Address limits are 16 bits wide, or 20 bits in the extended mode.
`timescale 1ns/10ps
`default_nettype none
module bhp_profiler (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Target bus pins, asynchronous
	input wire logic [bhp_pkg::ADDR_W-1:0] target_addr,
	input wire logic target_fetch,
	// Host configuration
	input wire logic run,
	input wire logic interval_profile_mode,
	input wire logic wide_addr,
	input wire logic [1:0] time_unit,
	input wire logic [bhp_pkg::ADDR_W-1:0] start_addr,
	input wire logic [bhp_pkg::ADDR_W-1:0] end_addr,
	input wire bhp_pkg::bhp_bin_wr_s bin_wr,
	input wire logic clear_counts,
	input wire logic clear_all,
	// Report stream to host
	output logic report_valid,
	input wire logic report_ready,
	output bhp_pkg::bhp_report_s report,
	// Status
	output logic timing_busy
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [bhp_pkg::ADDR_W-1:0] addr_m_r, addr_s_r, addr_m_nxt, addr_s_nxt;
	logic fetch_m_r, fetch_s_r, fetch_d_r, fetch_m_nxt, fetch_s_nxt, fetch_d_nxt;
	logic fetch_ev;

	// Two stages per pin; bus skew is tolerated since address settles before the strobe
	always_comb begin
		addr_m_nxt = target_addr;
		addr_s_nxt = addr_m_r;
		fetch_m_nxt = target_fetch;
		fetch_s_nxt = fetch_m_r;
		fetch_d_nxt = fetch_s_r;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			addr_m_r <= '0;
			addr_s_r <= '0;
			fetch_m_r <= 1'b0;
			fetch_s_r <= 1'b0;
			fetch_d_r <= 1'b0;
		end else begin
			addr_m_r <= addr_m_nxt;
			addr_s_r <= addr_s_nxt;
			fetch_m_r <= fetch_m_nxt;
			fetch_s_r <= fetch_s_nxt;
			fetch_d_r <= fetch_d_nxt;
		end
	end

	// One event per executed address, on the rising strobe
	assign fetch_ev = fetch_s_r & ~fetch_d_r;

	// ----------------------------------------
	// Address width
	// ----------------------------------------
	logic [bhp_pkg::ADDR_W-1:0] amask, cur_addr;

	assign amask = wide_addr ? bhp_pkg::MASK_WIDE : bhp_pkg::MASK_NARROW;
	assign cur_addr = addr_s_r & amask;

	// ----------------------------------------
	// Interval timer
	// ----------------------------------------
	bhp_pkg::bhp_state_e state_r, state_nxt;
	logic [bhp_pkg::TICK_CNT_W-1:0] tick_r, tick_nxt;
	logic [bhp_pkg::STEP_W-1:0] sub_r, sub_nxt, unit_steps, sub_sum;
	logic [bhp_pkg::TIME_W-1:0] elapsed_r, elapsed_nxt;
	logic [bhp_pkg::TIME_W-1:0] done_val_r, done_val_nxt;
	logic done_r, done_nxt;
	logic tick;

	// Steps of 10 us that make one time unit; the 10 us unit gets the two steps of one tick
	always_comb begin
		case (bhp_pkg::bhp_unit_e'(time_unit))
			bhp_pkg::UNIT_100US: unit_steps = bhp_pkg::STEPS_100US;
			bhp_pkg::UNIT_1MS: unit_steps = bhp_pkg::STEPS_1MS;
			bhp_pkg::UNIT_10MS: unit_steps = bhp_pkg::STEPS_10MS;
			default: unit_steps = bhp_pkg::STEPS_PER_TICK;
		endcase
	end

	assign tick = (tick_r == bhp_pkg::TICK_CNT_W'(bhp_pkg::TICK_CYCLES - 1));
	assign sub_sum = sub_r + bhp_pkg::STEPS_PER_TICK;

	// Timer runs only in 20 us ticks, which sets the true resolution
	always_comb begin
		state_nxt = state_r;
		tick_nxt = tick ? '0 : tick_r + 1'b1;
		sub_nxt = sub_r;
		elapsed_nxt = elapsed_r;
		done_nxt = 1'b0;
		done_val_nxt = done_val_r;
		case (state_r)
			bhp_pkg::ST_IDLE: begin
				if (run && interval_profile_mode && fetch_ev && cur_addr == (start_addr & amask)) begin
					state_nxt = bhp_pkg::ST_TIMING;
					tick_nxt = '0;
					sub_nxt = '0;
					elapsed_nxt = '0;
				end
			end
			bhp_pkg::ST_TIMING: begin
				if (!run || !interval_profile_mode) begin
					state_nxt = bhp_pkg::ST_IDLE;
				end else if (fetch_ev && cur_addr == (end_addr & amask)) begin
					state_nxt = bhp_pkg::ST_IDLE;
					done_nxt = 1'b1;
					done_val_nxt = elapsed_r;
				end else if (tick) begin
					// Stays here with no end address; elapsed saturates
					if (unit_steps == bhp_pkg::STEPS_PER_TICK) begin
						if (elapsed_r < bhp_pkg::TIME_MAX - 1'b1) begin
							elapsed_nxt = elapsed_r + 16'h0002;
						end else begin
							elapsed_nxt = bhp_pkg::TIME_MAX;
						end
					end else if (sub_sum >= unit_steps) begin
						sub_nxt = sub_sum - unit_steps;
						if (elapsed_r != bhp_pkg::TIME_MAX) begin
							elapsed_nxt = elapsed_r + 1'b1;
						end
					end else begin
						sub_nxt = sub_sum;
					end
				end
			end
			default: state_nxt = bhp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= bhp_pkg::ST_IDLE;
			tick_r <= '0;
			sub_r <= '0;
			elapsed_r <= '0;
			done_r <= 1'b0;
			done_val_r <= '0;
		end else begin
			state_r <= state_nxt;
			tick_r <= tick_nxt;
			sub_r <= sub_nxt;
			elapsed_r <= elapsed_nxt;
			done_r <= done_nxt;
			done_val_r <= done_val_nxt;
		end
	end

	assign timing_busy = (state_r == bhp_pkg::ST_TIMING);

	// ----------------------------------------
	// Bins and counters
	// ----------------------------------------
	logic [bhp_pkg::COUNT_W-1:0] cnt_r [bhp_pkg::NUM_BINS];

	for (genvar i = 0; i < bhp_pkg::NUM_BINS; i++) begin : g_bin
		bhp_pkg::bhp_bin_s bin_r, bin_nxt;
		logic [bhp_pkg::COUNT_W-1:0] cnt_nxt;
		logic [bhp_pkg::ADDR_W-1:0] key;
		logic hit;

		// Address mode compares the bus, interval mode the finished time
		always_comb begin
			key = interval_profile_mode ? bhp_pkg::ADDR_W'(done_val_r) : cur_addr;
			hit = bin_r.en && key >= (bin_r.lo & amask) && key <= (bin_r.hi & amask);
			if (interval_profile_mode) begin
				hit = hit && done_r;
			end else begin
				hit = hit && run && fetch_ev;
			end
		end

		always_comb begin
			bin_nxt = bin_r;
			cnt_nxt = cnt_r[i];
			if (clear_all) begin
				bin_nxt = '0;
			end else if (bin_wr.wr && bin_wr.idx == bhp_pkg::BIN_IDX_W'(i)) begin
				bin_nxt = bin_wr.bin;
			end
			if (clear_all || clear_counts) begin
				cnt_nxt = bhp_pkg::COUNT_RST;
			end else if (hit && cnt_r[i] != bhp_pkg::COUNT_MAX) begin
				cnt_nxt = cnt_r[i] + 1'b1;
			end
		end

		always_ff @(posedge clock) begin
			if (rst) begin
				bin_r <= '0;
				cnt_r[i] <= bhp_pkg::COUNT_RST;
			end else begin
				bin_r <= bin_nxt;
				cnt_r[i] <= cnt_nxt;
			end
		end
	end

	// ----------------------------------------
	// Report stream
	// ----------------------------------------
	logic [bhp_pkg::BIN_IDX_W-1:0] ptr_r, ptr_nxt;
	logic rpt_valid_r, rpt_valid_nxt;
	bhp_pkg::bhp_report_s rpt_r, rpt_nxt;

	// Round robin over all bins while running; the host only gives ready
	always_comb begin
		ptr_nxt = ptr_r;
		rpt_valid_nxt = rpt_valid_r;
		rpt_nxt = rpt_r;
		if (!rpt_valid_r || report_ready) begin
			rpt_valid_nxt = run;
			rpt_nxt.bin = ptr_r;
			rpt_nxt.count = cnt_r[ptr_r];
			ptr_nxt = (ptr_r == bhp_pkg::LAST_BIN) ? '0 : ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ptr_r <= '0;
			rpt_valid_r <= 1'b0;
			rpt_r <= '0;
		end else begin
			ptr_r <= ptr_nxt;
			rpt_valid_r <= rpt_valid_nxt;
			rpt_r <= rpt_nxt;
		end
	end

	assign report_valid = rpt_valid_r;
	assign report = rpt_r;
endmodule : bhp_profiler
`default_nettype wire

// ===== tb/bhp_asserts.sv
// Checker of the profiler report stream and interval timer
`timescale 1ns/10ps
`default_nettype none
module bhp_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Watched ports
	input wire logic run,
	input wire logic interval_profile_mode,
	input wire logic report_valid,
	input wire logic report_ready,
	input wire bhp_pkg::bhp_report_s report,
	input wire logic timing_busy
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// ----
	// Report stream
	// ----
	hold_valid_a: assert property (report_valid && !report_ready |=> report_valid)
		else $error("report word dropped before acceptance");
	hold_data_a: assert property (report_valid && !report_ready |=> $stable(report))
		else $error("report word changed while waiting");
	round_robin_a: assert property (report_valid && report_ready && run |=>
		report_valid && report.bin == (($past(report.bin) == 4'hE) ? 4'h0 : $past(report.bin) + 4'h1))
		else $error("report bin order broken");
	auto_send_a: assert property (run && !report_valid |=> report_valid)
		else $error("report not sent while running");
	stop_send_a: assert property (!run && (!report_valid || report_ready) |=> !report_valid)
		else $error("report sent while stopped");
	bin_range_a: assert property (report_valid |-> report.bin <= 4'hE)
		else $error("report names a bin past the last");
	// ----
	// Interval timer
	// ----
	timer_start_a: assert property ($rose(timing_busy) |-> $past(run && interval_profile_mode))
		else $error("timer started outside interval profiling");
	timer_abort_a: assert property (!run || !interval_profile_mode |=> !timing_busy)
		else $error("timer kept running after abort");
	// Main scenarios reached
	cover property ($fell(timing_busy));
	cover property (report_valid && report_ready && report.bin == 4'hE);
	cover property (report_valid && !run);
	cover property (report_valid && !report_ready);
endmodule : bhp_asserts
bind bhp_profiler bhp_asserts u_bhp_asserts (.clock(clock), .rst(rst), .run(run),
	.interval_profile_mode(interval_profile_mode), .report_valid(report_valid),
	.report_ready(report_ready), .report(report), .timing_busy(timing_busy));
`default_nettype wire

// ===== tb/bhp_target.sv
// Target processor model that executes addresses on the bus pins
`timescale 1ns/10ps
`default_nettype none
module bhp_target (
	// Clock
	input wire logic clock,
	// Target bus
	output logic [bhp_pkg::ADDR_W-1:0] target_addr,
	output logic target_fetch
);
	// Bus starts quiet
	initial begin
		target_addr = 20'h00000;
		target_fetch = 1'b0;
	end
	// One execution; strobe held three clocks each way to clear the synchroniser
	task automatic exec(input logic [bhp_pkg::ADDR_W-1:0] a);
		@(negedge clock);
		target_addr = a;
		target_fetch = 1'b1;
		repeat (3) @(negedge clock);
		target_fetch = 1'b0;
		target_addr = ~a; // Stale address never lingers
		repeat (3) @(negedge clock);
	endtask : exec
endmodule : bhp_target
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the histogram profiler
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock, rst, run, interval_profile_mode, wide_addr, clear_counts, clear_all;
	logic report_ready, report_valid, target_fetch, timing_busy;
	logic [1:0] time_unit;
	logic [bhp_pkg::ADDR_W-1:0] target_addr, start_addr, end_addr;
	bhp_pkg::bhp_bin_wr_s bin_wr;
	bhp_pkg::bhp_report_s report;
	int err_count = 0;
	int checks_done = 0;
	// ----
	// Design, target and clock
	// ----
	bhp_profiler u_bhp_profiler (.clock(clock), .rst(rst), .target_addr(target_addr),
		.target_fetch(target_fetch), .run(run), .interval_profile_mode(interval_profile_mode),
		.wide_addr(wide_addr), .time_unit(time_unit), .start_addr(start_addr), .end_addr(end_addr),
		.bin_wr(bin_wr), .clear_counts(clear_counts), .clear_all(clear_all), .report_valid(report_valid),
		.report_ready(report_ready), .report(report), .timing_busy(timing_busy));
	bhp_target u_bhp_target (.clock(clock), .target_addr(target_addr), .target_fetch(target_fetch));
	always #5 clock = ~clock;
	// ----
	// Helpers
	// ----
	task automatic report_and_stop;
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic compare(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : compare
	task automatic wr_bin(input logic [3:0] i, input logic [19:0] lo, input logic [19:0] hi);
		@(negedge clock);
		bin_wr = '{1'b1, i, '{1'b1, lo, hi}};
		@(negedge clock);
		bin_wr.wr = 1'b0;
	endtask : wr_bin
	// Width and interval window come from the caller
	task automatic set_config(input logic w, input logic [19:0] s, input logic [19:0] e);
		@(negedge clock);
		wide_addr = w;
		start_addr = s;
		end_addr = e;
	endtask : set_config
	// Ready is held high, so every bin passes by within one round
	task automatic expect_count(input logic [3:0] b, input logic [31:0] exp);
		int n;
		n = 0;
		@(negedge clock);
		while (!(report_valid === 1'b1 && report.bin === b) && n < 40) begin
			@(negedge clock);
			n++;
		end
		compare(n < 40 && report.count === exp, "bin count wrong");
		if (n >= 40) report_and_stop();
	endtask : expect_count
	// ----
	// Scenarios
	// ----
	task automatic address_bins;
		wr_bin(4'h0, 20'h00100, 20'h001FF);
		u_bhp_target.exec(20'h00120);
		run = 1'b1;
		u_bhp_target.exec(20'h00100);
		u_bhp_target.exec(20'h001FF);
		u_bhp_target.exec(20'h00200);
		u_bhp_target.exec(20'h10100);
		set_config(1'b1, 20'h00040, 20'h00080);
		wr_bin(4'hE, 20'h10000, 20'h1FFFF);
		u_bhp_target.exec(20'h10005);
		u_bhp_target.exec(20'h00150);
		expect_count(4'h0, 32'h00000004);
		expect_count(4'hE, 32'h00000001);
		expect_count(4'h1, 32'h00000000);
	endtask : address_bins
	// Host stalls the stream: the word must wait, then bins follow in order
	task automatic report_stall;
		bhp_pkg::bhp_report_s held;
		logic [3:0] nxt;
		@(negedge clock);
		report_ready = 1'b0;
		@(negedge clock);
		held = report;
		repeat (3) begin
			@(negedge clock);
			compare(report_valid === 1'b1 && report === held, "report word not held");
		end
		for (int k = 1; k < 9; k++) begin
			report_ready = k[0];
			@(negedge clock);
			if (k[0]) begin
				nxt = (held.bin == bhp_pkg::LAST_BIN) ? 4'h0 : held.bin + 4'h1;
				compare(report_valid === 1'b1 && report.bin === nxt, "report order wrong");
				held = report;
			end else begin
				compare(report_valid === 1'b1 && report === held, "report word lost");
			end
		end
		report_ready = 1'b1;
	endtask : report_stall
	// Clearing counts keeps the bins armed
	task automatic clear_keep_bins;
		@(negedge clock);
		clear_counts = 1'b1;
		@(negedge clock);
		clear_counts = 1'b0;
		u_bhp_target.exec(20'h00150);
		expect_count(4'h0, 32'h00000001);
		expect_count(4'hE, 32'h00000000);
	endtask : clear_keep_bins
	// Same 120 us routine timed in every unit; 10 ms and 1 ms round to zero
	task automatic interval_units;
		set_config(1'b1, 20'h00040, 20'h00080);
		@(negedge clock);
		clear_all = 1'b1;
		interval_profile_mode = 1'b1;
		@(negedge clock);
		clear_all = 1'b0;
		wr_bin(4'h3, 20'h0000A, 20'h0000E);
		wr_bin(4'h4, 20'h00001, 20'h00001);
		wr_bin(4'h5, 20'h00000, 20'h00000);
		for (int u = 0; u < 4; u++) begin
			time_unit = u[1:0];
			u_bhp_target.exec(20'h00040);
			compare(timing_busy === 1'b1, "timer not started");
			repeat (12000) @(negedge clock);
			u_bhp_target.exec(20'h00080);
			compare(timing_busy === 1'b0, "timer not stopped");
		end
		expect_count(4'h3, 32'h00000001);
		expect_count(4'h4, 32'h00000001);
		expect_count(4'h5, 32'h00000002);
	endtask : interval_units
	task automatic interval_open;
		u_bhp_target.exec(20'h00040);
		repeat (2500) @(negedge clock);
		compare(timing_busy === 1'b1, "timer stopped without end");
		run = 1'b0;
		repeat (2) @(negedge clock);
		compare(timing_busy === 1'b0 && report_valid === 1'b0, "stop ignored");
	endtask : interval_open
	// Main sequence
	initial begin
		{clock, run, interval_profile_mode, wide_addr, clear_counts, clear_all} = 6'h00;
		rst = 1'b1;
		report_ready = 1'b1;
		time_unit = 2'h0;
		start_addr = 20'h00000;
		end_addr = 20'h00000;
		bin_wr = '0;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		compare(report_valid === 1'b0 && timing_busy === 1'b0, "reset state");
		address_bins();
		report_stall();
		clear_keep_bins();
		interval_units();
		interval_open();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
